// ===== design/rtcyt_core.sv
// Purpose: year, time trimming and two-alarm registers with trimmed second divider
// Assumes: register port and alarm controls on core_clk; time counters on osc_clk
// Notes: trim settings cross domains by a toggle handshake; minute snapshots by a toggle with no ack
module rtcyt_core
  import rtcyt_pkg::*;
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_clk,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // halt detector
  input wire logic osc_halt_flag,
  // alarm control
  input wire logic alarm_a_enable,
  input wire logic alarm_b_enable,
  input wire logic alarm_a_flag_clear,
  input wire logic alarm_b_flag_clear,
  output logic alarm_a_match_flag,
  output logic alarm_b_match_flag,
  output logic irq_out_first_n,
  output logic irq_out_second_n,
  // time counters, osc_clk domain
  input wire logic [7:0] seconds_bcd,
  input wire logic [7:0] minute_bcd,
  input wire logic [7:0] hour_bcd,
  input wire logic [2:0] weekday_count,
  output logic second_tick
);

  function automatic logic [15:0] second_length(input logic [7:0] trim, input logic active,
                                                input logic [7:0] sec);
    logic [15:0] base;
    logic [5:0] mag;
    logic [7:0] step;
    base = trim[CRYSTAL_SELECT_BIT] ? COUNT_32K000 : COUNT_32K768; // [R3] [R4]
    mag = trim[TRIM_MAGNITUDE_MSB:0];
    step = 8'h00;
    second_length = base;
    if (active && (sec == SECOND_00 || sec == SECOND_20 || sec == SECOND_40) // [R5]
        && mag[5:1] != 5'h00) // [R9]
    begin
      if (!trim[TRIM_DIRECTION_BIT])
      begin
        step = {1'b0, mag - 6'h01, 1'b0}; // [R7]
        second_length = base + {8'h00, step};
      end
      else
      begin
        step = {1'b0, (~mag) + 6'h01, 1'b0}; // [R8]
        if (mag == 6'h00)
          step = 8'h80;
        second_length = base - {8'h00, step};
      end
    end
  endfunction

  function automatic logic alarm_hit(input logic [7:0] a_min, input logic [7:0] a_hour,
                                     input logic [7:0] a_days, input logic [7:0] t_min,
                                     input logic [7:0] t_hour, input logic [2:0] t_day);
    logic day_ok;
    day_ok = (t_day <= 3'h6) && a_days[t_day]; // [R15] [R16]
    alarm_hit = day_ok && (a_min == (t_min & MINUTE_USED))
                && (a_hour == (t_hour & HOUR_USED)); // [R13] [R14] [R20]
  endfunction

  // ---------------- core_clk domain ----------------
  logic [7:0] year_bcd;
  logic [7:0] time_trim;
  logic trim_active;
  logic [7:0] alarm_a_minute;
  logic [7:0] alarm_a_hour;
  logic [7:0] alarm_a_weekday_mask;
  logic [7:0] alarm_b_minute;
  logic [7:0] alarm_b_hour;
  logic [7:0] alarm_b_weekday_mask;
  logic halt_s1;
  logic halt_s2;
  logic halt_s3;
  logic halt_rise;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
      halt_s3 <= 1'b0;
    end
    else
    begin
      halt_s1 <= osc_halt_flag;
      halt_s2 <= halt_s1;
      halt_s3 <= halt_s2;
    end
  end

  assign halt_rise = halt_s2 && !halt_s3;

  // year and alarms keep whatever they held across a halt
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      year_bcd <= YEAR_RESET;
      alarm_a_minute <= ALARM_RESET;
      alarm_a_hour <= ALARM_RESET;
      alarm_a_weekday_mask <= ALARM_RESET;
      alarm_b_minute <= ALARM_RESET;
      alarm_b_hour <= ALARM_RESET;
      alarm_b_weekday_mask <= ALARM_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_YEAR: year_bcd <= reg_wdata; // [R1]
        ADDR_ALARM_A_MINUTE: alarm_a_minute <= reg_wdata & MINUTE_USED; // [R11] [R21]
        ADDR_ALARM_A_HOUR: alarm_a_hour <= reg_wdata & HOUR_USED; // [R11] [R21]
        ADDR_ALARM_A_MASK: alarm_a_weekday_mask <= reg_wdata & DAY_USED; // [R11] [R21]
        ADDR_ALARM_B_MINUTE: alarm_b_minute <= reg_wdata & MINUTE_USED; // [R12] [R21]
        ADDR_ALARM_B_HOUR: alarm_b_hour <= reg_wdata & HOUR_USED; // [R12] [R21]
        ADDR_ALARM_B_MASK: alarm_b_weekday_mask <= reg_wdata & DAY_USED; // [R12] [R21]
        default:
        begin
        end
      endcase
    end
  end

  // halt wins over a same-cycle write so the trim never survives a halt
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      time_trim <= TRIM_RESET;
      trim_active <= 1'b0;
    end
    else if (halt_rise)
    begin
      time_trim <= TRIM_RESET; // [R2]
      trim_active <= 1'b0;
    end
    else if (reg_wr && reg_addr == ADDR_TRIM)
    begin
      time_trim <= reg_wdata;
      trim_active <= 1'b1; // [R6]
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_YEAR: reg_rdata <= year_bcd; // [R1]
        ADDR_TRIM: reg_rdata <= time_trim;
        ADDR_ALARM_A_MINUTE: reg_rdata <= alarm_a_minute;
        ADDR_ALARM_A_HOUR: reg_rdata <= alarm_a_hour;
        ADDR_ALARM_A_MASK: reg_rdata <= alarm_a_weekday_mask;
        ADDR_ALARM_B_MINUTE: reg_rdata <= alarm_b_minute;
        ADDR_ALARM_B_HOUR: reg_rdata <= alarm_b_hour;
        ADDR_ALARM_B_MASK: reg_rdata <= alarm_b_weekday_mask;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // trim settings to osc domain: shadow held stable until the ack returns
  logic [8:0] trim_shadow;
  logic trim_req;
  logic ack_s1;
  logic ack_s2;
  logic trim_ack;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      trim_shadow <= {1'b0, TRIM_RESET};
      trim_req <= 1'b0;
    end
    else if (trim_req == ack_s2 && trim_shadow != {trim_active, time_trim})
    begin
      trim_shadow <= {trim_active, time_trim};
      trim_req <= !trim_req;
    end
  end

  // minute snapshot from osc domain, edge taken after the second stage
  logic evt_s1;
  logic evt_s2;
  logic evt_s3;
  logic minute_event;
  logic [7:0] snap_minute;
  logic [7:0] snap_hour;
  logic [2:0] snap_day;
  logic minute_toggle;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      evt_s1 <= 1'b0;
      evt_s2 <= 1'b0;
      evt_s3 <= 1'b0;
    end
    else
    begin
      ack_s1 <= trim_ack;
      ack_s2 <= ack_s1;
      evt_s1 <= minute_toggle;
      evt_s2 <= evt_s1;
      evt_s3 <= evt_s2;
    end
  end

  assign minute_event = evt_s2 != evt_s3;

  logic hit_a;
  logic hit_b;

  assign hit_a = alarm_hit(alarm_a_minute, alarm_a_hour, alarm_a_weekday_mask,
                           snap_minute, snap_hour, snap_day);
  assign hit_b = alarm_hit(alarm_b_minute, alarm_b_hour, alarm_b_weekday_mask,
                           snap_minute, snap_hour, snap_day);

  // a match in the clearing cycle wins over the clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      alarm_a_match_flag <= 1'b0;
    else if (!alarm_a_enable)
      alarm_a_match_flag <= 1'b0; // [R19]
    else if (minute_event && hit_a)
      alarm_a_match_flag <= 1'b1; // [R18]
    else if (alarm_a_flag_clear)
      alarm_a_match_flag <= 1'b0; // [R18]
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      alarm_b_match_flag <= 1'b0;
    else if (!alarm_b_enable)
      alarm_b_match_flag <= 1'b0; // [R19]
    else if (minute_event && hit_b)
      alarm_b_match_flag <= 1'b1; // [R18]
    else if (alarm_b_flag_clear)
      alarm_b_match_flag <= 1'b0; // [R18]
  end

  // lines follow the flags one cycle later
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_out_first_n <= 1'b1;
      irq_out_second_n <= 1'b1;
    end
    else
    begin
      irq_out_first_n <= !alarm_a_match_flag; // [R18]
      irq_out_second_n <= !alarm_b_match_flag; // [R18]
    end
  end

  // ---------------- osc_clk domain ----------------
  logic osc_rst_s1;
  logic osc_rst;

  always_ff @(posedge osc_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_rst_s1 <= 1'b1;
      osc_rst <= 1'b1;
    end
    else
    begin
      osc_rst_s1 <= 1'b0;
      osc_rst <= osc_rst_s1;
    end
  end

  logic req_s1;
  logic req_s2;
  logic [7:0] osc_trim;
  logic osc_trim_active;

  always_ff @(posedge osc_clk or posedge osc_rst)
  begin
    if (osc_rst)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end
    else
    begin
      req_s1 <= trim_req;
      req_s2 <= req_s1;
    end
  end

  // shadow is stable while req_s2 differs from ack, so sampling it is safe
  always_ff @(posedge osc_clk or posedge osc_rst)
  begin
    if (osc_rst)
    begin
      trim_ack <= 1'b0;
      osc_trim <= TRIM_RESET;
      osc_trim_active <= 1'b0;
    end
    else if (req_s2 != trim_ack)
    begin
      trim_ack <= req_s2;
      osc_trim <= trim_shadow[7:0];
      osc_trim_active <= trim_shadow[8];
    end
  end

  // only the second divider sees the trim; the crystal output is untouched
  logic [15:0] div_count;
  logic [15:0] div_length;

  assign div_length = second_length(osc_trim, osc_trim_active, seconds_bcd); // [R10]

  always_ff @(posedge osc_clk or posedge osc_rst)
  begin
    if (osc_rst)
    begin
      div_count <= 16'h0000;
      second_tick <= 1'b0;
    end
    else if (div_count >= div_length - 16'h0001)
    begin
      div_count <= 16'h0000; // [R4] [R5]
      second_tick <= 1'b1;
    end
    else
    begin
      div_count <= div_count + 16'h0001;
      second_tick <= 1'b0;
    end
  end

  // snapshot stays put for a whole minute, far longer than the crossing
  logic [7:0] last_minute;

  always_ff @(posedge osc_clk or posedge osc_rst)
  begin
    if (osc_rst)
    begin
      last_minute <= 8'h00;
      minute_toggle <= 1'b0;
      snap_minute <= 8'h00;
      snap_hour <= 8'h00;
      snap_day <= 3'h7;
    end
    else
    begin
      last_minute <= minute_bcd;
      if (minute_bcd != last_minute)
      begin
        snap_minute <= minute_bcd; // [R20]
        snap_hour <= hour_bcd;
        snap_day <= weekday_count;
        minute_toggle <= !minute_toggle;
      end
    end
  end

endmodule // rtcyt_core

// ===== design/rtcyt_pkg.sv
// Purpose: constants for the year, trimming and dual alarm register block
// Assumes: registers reached by 4-bit internal address, 8-bit data
// Notes: timekeeping divider runs on the crystal clock domain
//
// Contract
// [R1] year register is read/write, two BCD digits, tens high nibble
// [R2] oscillator halt clears trimming to zero; year and alarms keep stale values
// [R3] trimming bit 7 picks crystal: 0 gives 32.768 kHz, 1 gives 32.000 kHz
// [R4] untrimmed second lasts 32768 pulses, or 32000 with 32.000 kHz crystal
// [R5] trim adjusts divider only during seconds 00, 20 and 40
// [R6] writing the trimming register switches trimming on
// [R7] direction 0 lengthens second by (magnitude minus one) times two
// [R8] direction 1 shortens second by (inverted magnitude plus one) times two
// [R9] magnitude bits 5..1 all zero leaves the count unchanged
// [R10] trimming touches only the timekeeping count, never the oscillator output
// [R11] alarm A minute, hour, weekday mask sit at addresses 8h, 9h, Ah
// [R12] alarm B minute, hour, weekday mask sit at addresses Bh, Ch, Dh
// [R13] alarm hour bit 5 is PM flag in 12-hour mode, tens bit in 24-hour
// [R14] alarm hour uses counter encoding: midnight 12, noon 32 in 12-hour mode
// [R15] mask bits 0..6 match weekday values 0..6; only set days can match
// [R16] all mask bits zero means that alarm never fires
// [R17] host programs only real times before enabling an alarm
// [R18] enabled alarm sets flag on match; clearing flag releases interrupt line
// [R19] disabled alarm does nothing and its flag reads zero
// [R20] match needs equal minute, hour and set weekday bit, checked per minute
// [R21] unused upper alarm bits ignore writes and read zero
package rtcyt_pkg;

  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_ALARM_A_MINUTE = 4'h8;
  localparam logic [3:0] ADDR_ALARM_A_HOUR = 4'h9;
  localparam logic [3:0] ADDR_ALARM_A_MASK = 4'hA;
  localparam logic [3:0] ADDR_ALARM_B_MINUTE = 4'hB;
  localparam logic [3:0] ADDR_ALARM_B_HOUR = 4'hC;
  localparam logic [3:0] ADDR_ALARM_B_MASK = 4'hD;

  localparam logic [7:0] MINUTE_USED = 8'h7F;
  localparam logic [7:0] HOUR_USED = 8'h3F;
  localparam logic [7:0] DAY_USED = 8'h7F;
  localparam logic [7:0] YEAR_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;

  localparam int CRYSTAL_SELECT_BIT = 7;
  localparam int TRIM_DIRECTION_BIT = 6;
  localparam int TRIM_MAGNITUDE_MSB = 5;

  localparam logic [15:0] COUNT_32K768 = 16'h8000;
  localparam logic [15:0] COUNT_32K000 = 16'h7D00;

  localparam logic [7:0] SECOND_00 = 8'h00;
  localparam logic [7:0] SECOND_20 = 8'h20;
  localparam logic [7:0] SECOND_40 = 8'h40;

endpackage

// ===== verif/rtcyt_core_asserts.sv
// Purpose: register port and alarm output checks
// Assumes: all checks sit in the core_clk domain
// Notes: divider timing is left to the bench
module rtcyt_core_asserts
  import rtcyt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // alarms
  input wire logic alarm_a_enable,
  input wire logic alarm_b_enable,
  input wire logic alarm_a_match_flag,
  input wire logic alarm_b_match_flag,
  input wire logic irq_out_first_n,
  input wire logic irq_out_second_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_irq_a;
    $rose(alarm_a_match_flag) |=> !irq_out_first_n;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a late");
  property p_rel_b;
    $fell(alarm_b_match_flag) |=> irq_out_second_n;
  endproperty
  a_rel_b: assert property (p_rel_b) else $error("irq b held");
  property p_set_a;
    $rose(alarm_a_match_flag) |-> $past(alarm_a_enable);
  endproperty
  a_set_a: assert property (p_set_a) else $error("flag a while off");
  property p_off_a;
    !alarm_a_enable ##1 !alarm_a_enable |-> !alarm_a_match_flag;
  endproperty
  a_off_a: assert property (p_off_a) else $error("flag a not zero");
  property p_off_b;
    !alarm_b_enable ##1 !alarm_b_enable |-> !alarm_b_match_flag;
  endproperty
  a_off_b: assert property (p_off_b) else $error("flag b not zero");
  property p_unmapped;
    reg_rd && (reg_addr < 4'h6 || reg_addr > 4'hD) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_top7;
    reg_rd && reg_addr inside {4'h8, 4'hA, 4'hB, 4'hD} |=> !reg_rdata[7];
  endproperty
  a_top7: assert property (p_top7) else $error("bit 7 set");
  property p_top6;
    reg_rd && reg_addr inside {4'h9, 4'hC} |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_top6: assert property (p_top6) else $error("hour top bits");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_a: cover property ($rose(alarm_a_match_flag));
  c_b: cover property ($rose(alarm_b_match_flag));
  c_trim: cover property (reg_rd && reg_addr == 4'h7);
endmodule // rtcyt_core_asserts

bind rtcyt_core rtcyt_core_asserts i_chk (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .alarm_a_enable(alarm_a_enable),
  .alarm_b_enable(alarm_b_enable), .alarm_a_match_flag(alarm_a_match_flag),
  .alarm_b_match_flag(alarm_b_match_flag), .irq_out_first_n(irq_out_first_n),
  .irq_out_second_n(irq_out_second_n));

// ===== verif/rtcyt_core_tb.sv
// Purpose: self-checking bench for year, trimming and alarm registers
// Assumes: host model drives the register port, bench drives time counters
// Notes: a whole trimmed second outruns the cycle budget, so it is not timed
module rtcyt_core_tb
  import rtcyt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, osc_clk, rst, reg_wr, reg_rd, osc_halt_flag, second_tick;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, seconds_bcd, minute_bcd, hour_bcd, rd_val;
  logic [2:0] weekday_count;
  logic alarm_a_enable, alarm_b_enable, alarm_a_flag_clear, alarm_b_flag_clear;
  logic alarm_a_match_flag, alarm_b_match_flag, irq_out_first_n, irq_out_second_n;
  int mismatches, n_checks, cycles, ticks;
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    osc_clk = 1'b0;
    #3;
    forever #24 osc_clk = ~osc_clk;
  end
  rtcyt_core i_dut (.core_clk(core_clk), .rst(rst), .osc_clk(osc_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_halt_flag(osc_halt_flag), .alarm_a_enable(alarm_a_enable),
    .alarm_b_enable(alarm_b_enable), .alarm_a_flag_clear(alarm_a_flag_clear),
    .alarm_b_flag_clear(alarm_b_flag_clear), .alarm_a_match_flag(alarm_a_match_flag),
    .alarm_b_match_flag(alarm_b_match_flag), .irq_out_first_n(irq_out_first_n),
    .irq_out_second_n(irq_out_second_n), .seconds_bcd(seconds_bcd), .minute_bcd(minute_bcd),
    .hour_bcd(hour_bcd), .weekday_count(weekday_count), .second_tick(second_tick));
  rtcyt_host i_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: length %h want %h", $time, got, exp);
    end
  endtask
  // no full second fits the budget, so any tick here came too early
  always @(posedge osc_clk)
    if (second_tick !== 1'b0)
      ticks++;
  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    i_host.rd(a, rd_val);
    check8(rd_val, exp);
  endtask
  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // whole snapshot moves on one crystal edge
  task automatic set_time(input logic [7:0] m, input logic [7:0] h, input logic [2:0] d);
    @(posedge osc_clk);
    minute_bcd <= m;
    hour_bcd <= h;
    weekday_count <= d;
    wait_core(30);
  endtask
  task automatic t_regs();
    logic [3:0] a;
    rd_check(ADDR_TRIM, TRIM_RESET);
    for (int i = 6; i <= 13; i++)
    begin
      a = 4'(i);
      i_host.wr(a, 8'hFF);
      rd_check(a, (a == ADDR_ALARM_A_HOUR || a == ADDR_ALARM_B_HOUR) ? 8'h3F :
        (a > ADDR_TRIM) ? 8'h7F : 8'hFF);
    end
    i_host.wr(4'hE, 8'h55);
    rd_check(4'hE, 8'h00);
    rd_check(4'h5, 8'h00);
  endtask
  task automatic t_halt();
    i_host.wr(ADDR_TRIM, 8'h7E);
    rd_check(ADDR_TRIM, 8'h7E);
    osc_halt_flag <= 1'b1;
    wait_core(10);
    rd_check(ADDR_TRIM, 8'h00);
    osc_halt_flag <= 1'b0;
  endtask
  // divider length is checked, not timed: a trimmed second is too long to run
  task automatic trim_len(input logic [7:0] t, input logic [7:0] s, input logic [15:0] exp);
    i_host.wr(ADDR_TRIM, t);
    @(posedge osc_clk);
    seconds_bcd <= s;
    wait_core(40);
    check16(i_dut.div_length, exp);
  endtask
  task automatic t_trim();
    trim_len(8'h00, 8'h00, 16'h8000);
    trim_len(8'h05, 8'h20, 16'h8008);
    trim_len(8'h7E, 8'h00, 16'h7FFC);
    trim_len(8'h7E, 8'h05, 16'h8000);
    trim_len(8'h43, 8'h40, 16'h7F86);
    trim_len(8'h41, 8'h00, 16'h8000);
    trim_len(8'h85, 8'h40, 16'h7D08);
    trim_len(8'h81, 8'h20, 16'h7D00);
    osc_halt_flag <= 1'b1;
    wait_core(40);
    check16(i_dut.div_length, 16'h8000);
    osc_halt_flag <= 1'b0;
    check8(8'(ticks), 8'h00);
  endtask
  task automatic t_alarm();
    i_host.wr(ADDR_ALARM_A_MINUTE, 8'h30);
    i_host.wr(ADDR_ALARM_A_HOUR, 8'h12);
    i_host.wr(ADDR_ALARM_A_MASK, 8'h02);
    i_host.wr(ADDR_ALARM_B_MINUTE, 8'h30);
    i_host.wr(ADDR_ALARM_B_HOUR, 8'h12);
    i_host.wr(ADDR_ALARM_B_MASK, 8'h00);
    alarm_a_enable <= 1'b1;
    alarm_b_enable <= 1'b1;
    set_time(8'h30, 8'h12, 3'h1);
    check8({alarm_a_match_flag, irq_out_first_n}, 2'b10);
    check8({alarm_b_match_flag, irq_out_second_n}, 2'b01);
    alarm_a_flag_clear <= 1'b1;
    wait_core(1);
    alarm_a_flag_clear <= 1'b0;
    wait_core(3);
    check8({alarm_a_match_flag, irq_out_first_n}, 2'b01);
    i_host.wr(ADDR_ALARM_B_MASK, 8'h04);
    set_time(8'h31, 8'h12, 3'h2);
    set_time(8'h30, 8'h12, 3'h2);
    check8({alarm_a_match_flag, alarm_b_match_flag, irq_out_second_n}, 3'b010);
    alarm_b_flag_clear <= 1'b1;
    wait_core(1);
    alarm_b_flag_clear <= 1'b0;
    wait_core(3);
    check8({alarm_b_match_flag, irq_out_second_n}, 2'b01);
    i_host.wr(ADDR_ALARM_B_HOUR, 8'h32);
    set_time(8'h31, 8'h32, 3'h2);
    set_time(8'h30, 8'h32, 3'h2);
    check8({alarm_b_match_flag, irq_out_second_n}, 2'b10);
    alarm_b_enable <= 1'b0;
    wait_core(3);
    check8({alarm_b_match_flag, irq_out_second_n}, 2'b01);
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    rst = 1'b1;
    osc_halt_flag = 1'b0;
    {alarm_a_enable, alarm_b_enable, alarm_a_flag_clear, alarm_b_flag_clear} = 4'h0;
    {seconds_bcd, minute_bcd, hour_bcd} = {8'h05, 8'h00, 8'h00};
    weekday_count = 3'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wait_core(20);
    t_regs();
    t_halt();
    t_trim();
    t_alarm();
    finish_test();
  end
endmodule // rtcyt_core_tb

// ===== verif/rtcyt_host.sv
// Purpose: host side model issuing single-byte register accesses
// Assumes: one strobe pulse per access on core_clk
// Notes: callers hand it real BCD times, except t_regs, which fills every register with FFh
module rtcyt_host
(
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  // alarm values passed in are existing times, apart from the FFh that t_regs writes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // rtcyt_host
